// [core/susre_engine.sv]
/*
 * susre_engine: synchronous half-duplex serial port (master and slave) with
 * two-entry receive FIFO, overrun handling, 9-bit characters and an
 * Avalon-MM register slave.
 * Assumes serial pins arrive asynchronously and are resolved to wires by the
 * surroundings from the output enables; half period of the master clock is
 * (baud divisor + 1) system clocks and must exceed the synchroniser latency.
 */
`timescale 1ns/1ps

module susre_engine (
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_i,
	input  wire logic [4:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        serial_data_line_i,
	output logic             serial_data_line_o,
	output logic             serial_data_line_oe_n_o,
	input  wire logic        serial_clock_line_i,
	output logic             serial_clock_line_o,
	output logic             serial_clock_line_oe_n_o,
	output logic             receive_irq_flag_o,
	output logic             transmit_irq_flag_o,
	output logic             wake_irq_o
);

	typedef struct packed {
		logic                      bus_ack;
		logic [31:0]               rdata;
		logic                      clock_source_sel;
		logic                      tx_nine_bit_sel;
		logic                      transmit_enable_ctl;
		logic                      tx_ninth_bit;
		logic                      port_enable_ctl;
		logic                      rx_nine_bit_sel;
		logic                      single_receive_ctl;
		logic                      continuous_receive_ctl;
		logic                      receive_irq_enable;
		logic                      transmit_irq_enable;
		logic [15:0]               baud_div;
		logic [1:0][8:0]           fifo;
		logic [1:0]                fifo_cnt;
		logic                      rd_ptr;
		logic                      overrun_error_flag;
		logic                      overrun_single;
		logic [8:0]                receive_shift_reg;
		logic [3:0]                bit_cnt;
		susre_pkg::susre_state_type state;
		logic [8:0]                transmit_holding_reg;
		logic                      hold_full;
		logic [8:0]                transmit_shift_reg;
		logic [3:0]                tx_bits;
		logic [15:0]               baud_cnt;
		logic                      clk_out;
		logic                      data_out;
		logic [1:0]                data_sync;
		logic [1:0]                clk_sync;
		logic                      clk_prev;
	} susre_regs_type;

	susre_regs_type r;
	susre_regs_type next_r;

	function automatic logic [3:0] char_bits(input logic nine);
		char_bits = nine ? susre_pkg::CHAR_BITS9 : susre_pkg::CHAR_BITS8;
	endfunction

	logic       req;
	logic       accept;
	logic       rx_mode;
	logic       tx_mode;
	logic [8:0] head;

	assign req     = avs_read_i | avs_write_i;
	assign accept  = req & r.bus_ack & ce_i;
	assign head    = r.fifo[r.rd_ptr];
	// slave reception depends on continuous receive only
	assign rx_mode = r.clock_source_sel ? (r.single_receive_ctl | r.continuous_receive_ctl)
		: r.continuous_receive_ctl;
	assign tx_mode = ~r.single_receive_ctl & ~r.continuous_receive_ctl;

	always_comb begin
		logic       rise;
		logic       fall;
		logic       run;
		logic [8:0] shifted;
		logic [8:0] char;
		logic       wr_ptr;
		next_r  = r;
		rise    = 1'b0;
		fall    = 1'b0;
		run     = 1'b0;
		shifted = 9'h000;
		char    = 9'h000;
		wr_ptr  = 1'b0;

		// bus handshake: request sampled, answered on the following edge
		next_r.bus_ack = req & ~r.bus_ack;
		if (req & ~r.bus_ack) begin
			next_r.rdata = 32'h0000_0000;
			unique case (avs_address_i)
				susre_pkg::OFF_TX_STATUS: begin
					next_r.rdata[susre_pkg::TXS_CLK_SRC]     = r.clock_source_sel;
					next_r.rdata[susre_pkg::TXS_NINE]        = r.tx_nine_bit_sel;
					next_r.rdata[susre_pkg::TXS_TX_EN]       = r.transmit_enable_ctl;
					next_r.rdata[susre_pkg::TXS_SHIFT_EMPTY] = r.state != susre_pkg::ST_TX;
					next_r.rdata[susre_pkg::TXS_NINTH]       = r.tx_ninth_bit;
				end
				susre_pkg::OFF_RX_STATUS: begin
					next_r.rdata[susre_pkg::RXS_PORT_EN] = r.port_enable_ctl;
					next_r.rdata[susre_pkg::RXS_NINE]    = r.rx_nine_bit_sel;
					next_r.rdata[susre_pkg::RXS_SINGLE]  = r.single_receive_ctl;
					next_r.rdata[susre_pkg::RXS_CONT]    = r.continuous_receive_ctl;
					next_r.rdata[susre_pkg::RXS_OVERRUN] = r.overrun_error_flag;
					next_r.rdata[susre_pkg::RXS_NINTH]   = head[8];
				end
				susre_pkg::OFF_RX_DATA: begin
					next_r.rdata[7:0] = head[7:0];
				end
				susre_pkg::OFF_BAUD: begin
					next_r.rdata[15:0] = r.baud_div;
				end
				susre_pkg::OFF_IRQ: begin
					next_r.rdata[susre_pkg::IRQ_RX_FLAG]   = r.fifo_cnt != 2'h0;
					next_r.rdata[susre_pkg::IRQ_TX_FLAG]   = transmit_irq_flag_o;
					next_r.rdata[susre_pkg::IRQ_RX_ENABLE] = r.receive_irq_enable;
					next_r.rdata[susre_pkg::IRQ_TX_ENABLE] = r.transmit_irq_enable;
				end
				default: begin
					next_r.rdata = 32'h0000_0000;
				end
			endcase
		end

		// pins cross into the clock domain through two flip-flops
		next_r.data_sync = {r.data_sync[0], serial_data_line_i};
		next_r.clk_sync  = {r.clk_sync[0], serial_clock_line_i};
		next_r.clk_prev  = r.clk_sync[1];

		// pop before push so a full FIFO read in the same cycle frees a slot
		if (accept & avs_read_i & (avs_address_i == susre_pkg::OFF_RX_DATA)) begin
			if (r.fifo_cnt != 2'h0) begin
				next_r.fifo_cnt = r.fifo_cnt - 2'h1;
				next_r.rd_ptr   = ~r.rd_ptr;
			end
			if (r.overrun_error_flag & r.overrun_single) begin
				next_r.overrun_error_flag = 1'b0;
			end
		end
		if (r.overrun_error_flag & ~r.overrun_single & ~r.continuous_receive_ctl) begin
			next_r.overrun_error_flag = 1'b0;
		end

		// master clock: idles low, toggles every (divisor + 1) cycles while a character runs
		if (r.clock_source_sel) begin
			run = r.port_enable_ctl & ((r.state == susre_pkg::ST_TX)
				| ((r.state == susre_pkg::ST_RX) & rx_mode & ~r.overrun_error_flag));
			if (run) begin
				if (r.baud_cnt == r.baud_div) begin
					next_r.baud_cnt = 16'h0000;
					next_r.clk_out  = ~r.clk_out;
					rise            = ~r.clk_out;
					fall            = r.clk_out;
				end else begin
					next_r.baud_cnt = r.baud_cnt + 16'h0001;
				end
			end else begin
				next_r.baud_cnt = 16'h0000;
				next_r.clk_out  = 1'b0;
			end
		end else begin
			rise = r.clk_sync[1] & ~r.clk_prev;
			fall = ~r.clk_sync[1] & r.clk_prev;
		end

		unique case (r.state)
			susre_pkg::ST_IDLE: begin
				next_r.bit_cnt = 4'h0;
				if (rx_mode) begin
					next_r.state = susre_pkg::ST_RX;
				end else if (r.transmit_enable_ctl & r.hold_full) begin
					next_r.transmit_shift_reg = r.transmit_holding_reg;
					next_r.tx_bits            = char_bits(r.tx_nine_bit_sel);
					next_r.hold_full          = 1'b0;
					next_r.state              = susre_pkg::ST_TX;
				end
			end
			susre_pkg::ST_RX: begin
				if (!rx_mode) begin
					// partial character is thrown away, clock already parked low
					next_r.state    = susre_pkg::ST_IDLE;
					next_r.clk_out  = 1'b0;
					next_r.baud_cnt = 16'h0000;
				end else if (fall) begin
					shifted = {r.data_sync[1], r.receive_shift_reg[8:1]};
					next_r.receive_shift_reg = shifted;
					if (r.bit_cnt == char_bits(r.rx_nine_bit_sel) - 4'h1) begin
						next_r.bit_cnt = 4'h0;
						char = r.rx_nine_bit_sel ? shifted : {1'b0, shifted[8:1]};
						if (r.clock_source_sel) begin
							next_r.single_receive_ctl = 1'b0;
						end
						if (!r.overrun_error_flag) begin
							if (next_r.fifo_cnt != susre_pkg::FIFO_DEPTH) begin
								wr_ptr = r.rd_ptr ^ next_r.fifo_cnt[0];
								next_r.fifo[wr_ptr] = char;
								next_r.fifo_cnt     = next_r.fifo_cnt + 2'h1;
							end else begin
								next_r.overrun_error_flag = 1'b1;
								next_r.overrun_single     = ~r.continuous_receive_ctl;
							end
						end
					end else begin
						next_r.bit_cnt = r.bit_cnt + 4'h1;
					end
				end
			end
			susre_pkg::ST_TX: begin
				if (rx_mode | ~r.transmit_enable_ctl) begin
					next_r.state    = susre_pkg::ST_IDLE;
					next_r.clk_out  = 1'b0;
					next_r.baud_cnt = 16'h0000;
				end else if (rise) begin
					next_r.data_out = r.transmit_shift_reg[0];
				end else if (fall) begin
					next_r.transmit_shift_reg = {1'b0, r.transmit_shift_reg[8:1]};
					if (r.bit_cnt == r.tx_bits - 4'h1) begin
						next_r.bit_cnt = 4'h0;
						if (r.hold_full) begin
							next_r.transmit_shift_reg = r.transmit_holding_reg;
							next_r.tx_bits            = char_bits(r.tx_nine_bit_sel);
							next_r.hold_full          = 1'b0;
						end else begin
							next_r.state = susre_pkg::ST_IDLE;
						end
					end else begin
						next_r.bit_cnt = r.bit_cnt + 4'h1;
					end
				end
			end
			default: begin
				next_r.state = susre_pkg::ST_IDLE;
			end
		endcase

		// software writes land after the engine so a software set beats a hardware clear
		if (accept & avs_write_i) begin
			unique case (avs_address_i)
				susre_pkg::OFF_TX_STATUS: begin
					next_r.clock_source_sel    = avs_writedata_i[susre_pkg::TXS_CLK_SRC];
					next_r.tx_nine_bit_sel     = avs_writedata_i[susre_pkg::TXS_NINE];
					next_r.transmit_enable_ctl = avs_writedata_i[susre_pkg::TXS_TX_EN];
					next_r.tx_ninth_bit        = avs_writedata_i[susre_pkg::TXS_NINTH];
				end
				susre_pkg::OFF_RX_STATUS: begin
					next_r.port_enable_ctl        = avs_writedata_i[susre_pkg::RXS_PORT_EN];
					next_r.rx_nine_bit_sel        = avs_writedata_i[susre_pkg::RXS_NINE];
					next_r.single_receive_ctl     = avs_writedata_i[susre_pkg::RXS_SINGLE];
					next_r.continuous_receive_ctl = avs_writedata_i[susre_pkg::RXS_CONT];
				end
				susre_pkg::OFF_TX_HOLD: begin
					// a write while full replaces the waiting word; software waits for the flag
					next_r.transmit_holding_reg = {r.tx_ninth_bit, avs_writedata_i[7:0]};
					next_r.hold_full            = 1'b1;
				end
				susre_pkg::OFF_BAUD: begin
					next_r.baud_div = avs_writedata_i[15:0];
				end
				susre_pkg::OFF_IRQ: begin
					next_r.receive_irq_enable  = avs_writedata_i[susre_pkg::IRQ_RX_ENABLE];
					next_r.transmit_irq_enable = avs_writedata_i[susre_pkg::IRQ_TX_ENABLE];
				end
				default: begin
					next_r.baud_div = next_r.baud_div;
				end
			endcase
		end

		// port disabled holds the serial engine in reset; control bits survive
		if (!r.port_enable_ctl) begin
			next_r.state              = susre_pkg::ST_IDLE;
			next_r.fifo_cnt           = 2'h0;
			next_r.rd_ptr             = 1'b0;
			next_r.overrun_error_flag = 1'b0;
			next_r.overrun_single     = 1'b0;
			next_r.hold_full          = 1'b0;
			next_r.bit_cnt            = 4'h0;
			next_r.baud_cnt           = 16'h0000;
			next_r.clk_out            = 1'b0;
			next_r.data_out           = 1'b0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			r          <= '0;
			r.baud_div <= susre_pkg::BAUD_RST;
		end else if (ce_i) begin
			r <= next_r;
		end
	end

	assign avs_readdata_o    = r.rdata;
	assign avs_waitrequest_o = req & ~(r.bus_ack & ce_i);

	assign serial_data_line_o       = r.data_out;
	// data driver only in transmit configuration, released while receiving
	assign serial_data_line_oe_n_o  = ~(r.port_enable_ctl & tx_mode
		& r.transmit_enable_ctl);
	assign serial_clock_line_o      = r.clk_out;
	assign serial_clock_line_oe_n_o = ~(r.port_enable_ctl & r.clock_source_sel);

	assign receive_irq_flag_o  = r.fifo_cnt != 2'h0;
	assign transmit_irq_flag_o = r.port_enable_ctl & r.transmit_enable_ctl & ~r.hold_full;
	// wake request works in slave mode with no software activity
	assign wake_irq_o = (receive_irq_flag_o & r.receive_irq_enable)
		| (transmit_irq_flag_o & r.transmit_irq_enable);

endmodule // susre_engine

// [core/susre_pkg.sv]
/*
 * susre_pkg: register map, field positions, reset values and state type of the
 * synchronous serial receive/transmit engine.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
package susre_pkg;

	// byte offsets of the register words
	localparam logic [4:0] OFF_TX_STATUS = 5'h00;
	localparam logic [4:0] OFF_RX_STATUS = 5'h04;
	localparam logic [4:0] OFF_RX_DATA   = 5'h08;
	localparam logic [4:0] OFF_TX_HOLD   = 5'h0c;
	localparam logic [4:0] OFF_BAUD      = 5'h10;
	localparam logic [4:0] OFF_IRQ       = 5'h14;

	// transmit status/control fields
	localparam int TXS_CLK_SRC     = 7;
	localparam int TXS_NINE        = 6;
	localparam int TXS_TX_EN       = 5;
	localparam int TXS_SHIFT_EMPTY = 1;
	localparam int TXS_NINTH       = 0;

	// receive status/control fields
	localparam int RXS_PORT_EN = 7;
	localparam int RXS_NINE    = 6;
	localparam int RXS_SINGLE  = 5;
	localparam int RXS_CONT    = 4;
	localparam int RXS_OVERRUN = 1;
	localparam int RXS_NINTH   = 0;

	// interrupt flag/enable word
	localparam int IRQ_RX_FLAG   = 0;
	localparam int IRQ_TX_FLAG   = 1;
	localparam int IRQ_RX_ENABLE = 8;
	localparam int IRQ_TX_ENABLE = 9;

	// reset values and character geometry
	localparam logic [15:0] BAUD_RST   = 16'h0003;
	localparam logic [3:0]  CHAR_BITS8 = 4'h8;
	localparam logic [3:0]  CHAR_BITS9 = 4'h9;
	localparam logic [1:0]  FIFO_DEPTH = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_TX,
		ST_RX
	} susre_state_type;

endpackage

// [dv/susre_engine_tb.sv]
/* susre_engine_tb: register-level tests of the serial engine in master and slave roles.
   Assumes susre_far_end on the serial lines and the bound checker. */
`timescale 1ns/1ps
module susre_engine_tb;
	logic        clock_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [4:0]  avs_address_i = 5'h00;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic [31:0] rdv;
	logic        avs_waitrequest_o, dat_o, dat_oe_n, clk_o, clk_oe_n, p_clk, p_dat;
	logic        receive_irq_flag_o, transmit_irq_flag_o, wake_irq_o;
	logic [7:0]  vals [3] = '{8'ha5, 8'h3c, 8'h96};
	wire         clk_w = clk_oe_n ? p_clk : clk_o;
	wire         dat_w = dat_oe_n ? p_dat : dat_o;
	int          n_mismatch = 0, checks_done = 0, rises = 0, cyc = 0, i;

	susre_engine dut_u (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.serial_data_line_i(dat_w), .serial_data_line_o(dat_o),
		.serial_data_line_oe_n_o(dat_oe_n), .serial_clock_line_i(clk_w),
		.serial_clock_line_o(clk_o), .serial_clock_line_oe_n_o(clk_oe_n),
		.receive_irq_flag_o(receive_irq_flag_o), .transmit_irq_flag_o(transmit_irq_flag_o),
		.wake_irq_o(wake_irq_o)
	);
	susre_far_end part_u (.clk_line_i(clk_w), .data_line_i(dat_w), .clk_o(p_clk), .data_o(p_dat));

	always #2.5 clock_i = ~clock_i;
	always @(posedge clk_w) rises++;
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// request held until waitrequest is seen low at a rising edge
	task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		do begin
			@(posedge clock_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 40);
		rdv = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (n >= 40) n_mismatch++;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
		xfer(1'b0, a, 32'h0);
		chk(nm, rdv, e);
	endtask
	// registered flags need a few edges to follow a register access
	task automatic settle();
		repeat (3) @(posedge clock_i);
	endtask
	task automatic poll_single();
		int n;
		n = 0;
		do begin
			xfer(1'b0, susre_pkg::OFF_RX_STATUS, 32'h0);
			n++;
		end while (rdv[susre_pkg::RXS_SINGLE] !== 1'b0 && n < 200);
		if (n >= 200) n_mismatch++;
	endtask

	initial begin
		repeat (10) @(posedge clock_i);
		rst_n_i <= 1'b1;
		rd(susre_pkg::OFF_BAUD, {16'h0, susre_pkg::BAUD_RST}, "baud reset");
		rd(susre_pkg::OFF_TX_STATUS, 32'h2, "tx status reset");
		rd(susre_pkg::OFF_RX_STATUS, 32'h0, "rx status reset");
		wr(5'h18, 32'hff);
		rd(5'h18, 32'h0, "unmapped");
		// master single receive three times without reading: third overruns
		wr(susre_pkg::OFF_TX_STATUS, 32'h80);
		part_u.follow = 1'b1;
		foreach (vals[k]) begin
			part_u.src = {56'h0, vals[k]};
			rises = 0;
			wr(susre_pkg::OFF_RX_STATUS, 32'ha0);
			poll_single();
			chk("master clocks", rises, 32'h8);
		end
		chk("rx flag", receive_irq_flag_o, 1'b1);
		rd(susre_pkg::OFF_RX_STATUS, 32'h82, "overrun set");
		rd(susre_pkg::OFF_RX_DATA, 32'ha5, "oldest kept");
		rd(susre_pkg::OFF_RX_STATUS, 32'h80, "overrun cleared");
		rd(susre_pkg::OFF_RX_DATA, 32'h3c, "second entry");
		settle();
		chk("fifo empty", receive_irq_flag_o, 1'b0);
		// nine-bit, both controls set, continuous cleared in the third character
		part_u.src = {46'h2aaa_aaaa_aaaa, 9'h0c3, 9'h13c};
		rises = 0;
		wr(susre_pkg::OFF_RX_STATUS, 32'hf0);
		for (i = 0; i < 1000 && rises < 22; i++) @(posedge clock_i);
		wr(susre_pkg::OFF_RX_STATUS, 32'hc0);
		i = rises;
		repeat (40) @(posedge clock_i);
		chk("clock stopped", rises, i);
		rd(susre_pkg::OFF_RX_STATUS, 32'hc1, "ninth of head");
		rd(susre_pkg::OFF_RX_DATA, 32'h3c, "nine-bit low");
		rd(susre_pkg::OFF_RX_STATUS, 32'hc0, "ninth advanced");
		rd(susre_pkg::OFF_RX_DATA, 32'hc3, "back to back");
		settle();
		chk("partial dropped", receive_irq_flag_o, 1'b0);
		part_u.follow = 1'b0;
		// slave transmit, two words queued
		wr(susre_pkg::OFF_TX_STATUS, 32'h20);
		wr(susre_pkg::OFF_RX_STATUS, 32'h80);
		wr(susre_pkg::OFF_IRQ, 32'h200);
		wr(susre_pkg::OFF_TX_HOLD, 32'h5a);
		settle();
		for (i = 0; i < 100 && transmit_irq_flag_o !== 1'b1; i++) @(posedge clock_i);
		wr(susre_pkg::OFF_TX_HOLD, 32'h96);
		settle();
		chk("second held", transmit_irq_flag_o, 1'b0);
		chk("clock released", clk_oe_n, 1'b1);
		part_u.clocks(16'h0, 8);
		chk("first word", part_u.got, 16'h5a);
		settle();
		chk("tx flag", transmit_irq_flag_o, 1'b1);
		chk("tx wake", wake_irq_o, 1'b1);
		part_u.clocks(16'h0, 8);
		chk("second word", part_u.got, 16'h96);
		rd(susre_pkg::OFF_TX_STATUS, 32'h22, "shift empty");
		// slave receive: single alone does nothing, continuous receives
		wr(susre_pkg::OFF_TX_STATUS, 32'h0);
		wr(susre_pkg::OFF_RX_STATUS, 32'ha0);
		part_u.clocks(16'h33, 8);
		settle();
		chk("single ignored", receive_irq_flag_o, 1'b0);
		wr(susre_pkg::OFF_IRQ, 32'h100);
		wr(susre_pkg::OFF_RX_STATUS, 32'h90);
		part_u.clocks(16'h6e, 8);
		settle();
		chk("slave rx flag", receive_irq_flag_o, 1'b1);
		chk("rx wake", wake_irq_o, 1'b1);
		rd(susre_pkg::OFF_RX_DATA, 32'h6e, "slave word");
		// master transmit of a nine-bit word, set up in the software order
		wr(susre_pkg::OFF_BAUD, {16'h0, susre_pkg::BAUD_RST});
		wr(susre_pkg::OFF_RX_STATUS, 32'h80);
		wr(susre_pkg::OFF_TX_STATUS, 32'he1);
		part_u.seen = 16'h0;
		rises = 0;
		wr(susre_pkg::OFF_TX_HOLD, 32'h5a);
		for (i = 0; i < 400 && rises < 9; i++) @(posedge clock_i);
		repeat (12) @(posedge clock_i);
		chk("master tx clocks", rises, 32'h9);
		chk("master tx data", part_u.seen[15:7], 9'h15a);
		rd(susre_pkg::OFF_TX_STATUS, 32'he3, "master tx done");
		wrap_up();
	end
endmodule // susre_engine_tb

// [dv/susre_far_end.sv]
/* susre_far_end: behavioural far-end serial device, master or slave.
   Assumes the bench resolves both lines from the enables and sets src and follow. */
`timescale 1ns/1ps
module susre_far_end (
	input  wire logic clk_line_i,
	input  wire logic data_line_i,
	output logic      clk_o,
	output logic      data_o
);
	logic [63:0] src = 64'h0;
	logic        follow = 1'b0;
	logic [15:0] got = 16'h0;
	logic [15:0] seen = 16'h0;
	initial clk_o = 1'b0;
	initial data_o = 1'b1;
	// as source for a receiving master: next bit on each leading edge
	always @(posedge clk_line_i) if (follow) begin
		data_o <= src[0];
		src    <= src >> 1;
	end
	// as slave of a transmitting master: one bit taken on each trailing edge
	always @(negedge clk_line_i) seen <= {data_line_i, seen[15:1]};
	// as master: one clock per bit at 80 ns, clock idles low between frames
	task automatic clocks(input logic [15:0] w, input int n);
		for (int i = 0; i < n; i++) begin
			clk_o <= 1'b1;
			data_o <= w[i];
			#40;
			clk_o <= 1'b0;
			got[i] = data_line_i;
			#40;
		end
		data_o <= ~data_o; // released line must not keep the last bit
	endtask
endmodule // susre_far_end

// [dv/susre_properties.sv]
/* susre_properties: port-level assertions for the serial engine, bound to susre_engine.
   Assumes the baud divisor stays at its reset value (four clocks per half period). */
`timescale 1ns/1ps
module susre_checker (
	input wire logic        clock_i,
	input wire logic        rst_n_i,
	input wire logic        ce_i,
	input wire logic [4:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic        serial_data_line_i,
	input wire logic        serial_data_line_o,
	input wire logic        serial_data_line_oe_n_o,
	input wire logic        serial_clock_line_i,
	input wire logic        serial_clock_line_o,
	input wire logic        serial_clock_line_oe_n_o,
	input wire logic        receive_irq_flag_o,
	input wire logic        transmit_irq_flag_o,
	input wire logic        wake_irq_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	logic       acc;
	logic       rd_data;
	logic       wr_rxs;
	logic       lim_on;
	logic [4:0] rises;
	logic [4:0] lim;
	logic [1:0] irq_en;
	assign acc     = (avs_read_i || avs_write_i) && ce_i && !avs_waitrequest_o;
	assign rd_data = acc && avs_read_i && avs_address_i == susre_pkg::OFF_RX_DATA;
	assign wr_rxs  = acc && avs_write_i && avs_address_i == susre_pkg::OFF_RX_STATUS;
	// rising clock edges since the receive status word was last written; limit armed only when single receive alone was written
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || wr_rxs) begin
			rises  <= 5'h00;
			lim_on <= wr_rxs && avs_writedata_i[susre_pkg::RXS_SINGLE]
				&& !avs_writedata_i[susre_pkg::RXS_CONT];
			lim    <= avs_writedata_i[susre_pkg::RXS_NINE] ? 5'h09 : 5'h08;
		end else if ($rose(serial_clock_line_o) && rises != 5'h1f) begin
			rises <= rises + 5'h01;
		end
	end
	// interrupt enables as software last wrote them; a port disable keeps them
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			irq_en <= 2'h0;
		end else if (acc && avs_write_i && avs_address_i == susre_pkg::OFF_IRQ) begin
			irq_en <= {avs_writedata_i[susre_pkg::IRQ_TX_ENABLE],
				avs_writedata_i[susre_pkg::IRQ_RX_ENABLE]};
		end
	end
	sequence s_req_new;
		(avs_read_i || avs_write_i) && ce_i && avs_waitrequest_o;
	endsequence
	sequence s_master_push;
		$rose(receive_irq_flag_o) && !serial_clock_line_oe_n_o;
	endsequence
	a_bus_one_wait: assert property (s_req_new ##1 ce_i |-> !avs_waitrequest_o)
		else $error("register request kept waiting too long");
	a_single_count: assert property (lim_on |-> rises <= lim)
		else $error("single receive gave too many clock cycles");
	a_low_phase: assert property ($fell(serial_clock_line_o) |-> !serial_clock_line_o [*4])
		else $error("master clock low phase too short");
	a_abort_stops: assert property (wr_rxs && !avs_writedata_i[susre_pkg::RXS_CONT]
		&& !avs_writedata_i[susre_pkg::RXS_SINGLE] |=> ##1 !serial_clock_line_o [*8])
		else $error("master clock ran on after receive was cleared");
	a_push_on_fall: assert property (s_master_push |-> !serial_clock_line_o
		&& ($past(serial_clock_line_o) || $past(serial_clock_line_o, 2)
		|| $past(serial_clock_line_o, 3)))
		else $error("receive flag rose away from a trailing clock edge");
	a_rx_line_free: assert property ($rose(receive_irq_flag_o) |-> serial_data_line_oe_n_o)
		else $error("data line driven while receiving");
	a_flag_cause: assert property ($fell(receive_irq_flag_o) |->
		$past(rd_data || wr_rxs) || $past(rd_data || wr_rxs, 2))
		else $error("receive flag dropped without a data read");
	a_wake_cause: assert property (wake_irq_o == ((receive_irq_flag_o && irq_en[0])
		|| (transmit_irq_flag_o && irq_en[1])))
		else $error("wake request does not follow flags and enables");
	a_slave_clk_quiet: assert property (serial_clock_line_oe_n_o |=>
		$stable(serial_clock_line_o))
		else $error("clock output moved while released");
endmodule // susre_checker

bind susre_engine susre_checker chk_u (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.serial_data_line_i(serial_data_line_i), .serial_data_line_o(serial_data_line_o),
	.serial_data_line_oe_n_o(serial_data_line_oe_n_o), .serial_clock_line_i(serial_clock_line_i),
	.serial_clock_line_o(serial_clock_line_o), .serial_clock_line_oe_n_o(serial_clock_line_oe_n_o),
	.receive_irq_flag_o(receive_irq_flag_o), .transmit_irq_flag_o(transmit_irq_flag_o),
	.wake_irq_o(wake_irq_o)
);
